// file: fsid_map.vh
// fsid_map.vh: opcodes, status bit layout, phase counts and timing of the flash command decoder
`ifndef FSID_MAP_VH
`define FSID_MAP_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define FSID_OP_WREN      8'h06
`define FSID_OP_VWREN     8'h50
`define FSID_OP_WRDI      8'h04
`define FSID_OP_RDSR1     8'h05
`define FSID_OP_RDSR2     8'h35
`define FSID_OP_WRSR      8'h01
`define FSID_OP_READ      8'h03
`define FSID_OP_PP        8'h02
`define FSID_OP_QPP       8'h32
`define FSID_OP_SE        8'h20
`define FSID_OP_BE32      8'h52
`define FSID_OP_BE64      8'hD8
`define FSID_OP_CE1       8'hC7
`define FSID_OP_CE2       8'h60
`define FSID_OP_RPD_ID    8'hAB
`define FSID_OP_MFID      8'h90
`define FSID_OP_MFID_DUAL 8'h92
`define FSID_OP_MFID_QUAD 8'h94
`define FSID_OP_SEC_ERASE 8'h44
`define FSID_OP_SEC_PROG  8'h42
`define FSID_OP_SEC_READ  8'h48

// ****************************************************************
// status word layout (bits 15..0)
// ****************************************************************
`define FSID_BIT_BUSY     0
`define FSID_BIT_WEL      1
`define FSID_BIT_SR_PROTECT_1     8
`define FSID_BIT_QE       9
`define FSID_BIT_CMP      14
`define FSID_LB_LO        11
`define FSID_LB_HI        13
`define FSID_SR1_WMASK    8'hFC
`define FSID_SR2_WMASK    8'h7B
`define FSID_SR_RESET     16'h0000

// ****************************************************************
// security register addressing
// ****************************************************************
`define FSID_SEC_HI       8'h00
`define FSID_SEC_REG1     8'h10
`define FSID_SEC_REG2     8'h20
`define FSID_SEC_REG3     8'h30

// ****************************************************************
// phase counts in serial clocks after chip select falls
// ****************************************************************
`define FSID_OPC_CLKS     7'd8
`define FSID_ADDR_END     7'd32
`define FSID_SECRD_START  7'd40
`define FSID_DUAL_START   7'd24
`define FSID_QUAD_START   7'd20
`define FSID_WRSR_SHORT   7'd16
`define FSID_WRSR_LONG    7'd24
`define FSID_NO_DATA      7'd127

// ****************************************************************
// timing
// ****************************************************************
`define FSID_CLK_MHZ      50
`define FSID_TW_US        15000
`define FSID_TW_CYCLES    (`FSID_TW_US * `FSID_CLK_MHZ)

`endif

// file: fsid_cmd.v
// fsid_cmd.v: serial flash command decoder for id, security, latch, status and data reads
`timescale 1ns/100ps
`include "fsid_map.vh"

// ****************************************************************
// Summary of operation
// [R1] opcode ABh, three dummy bytes, then device id repeats until deselect
// [R2] opcode 90h, two dummies and 00h, then manufacturer and device id bytes
// [R3] opcode 92h, address and mode two bits per clock, ids returned on two lines
// [R4] opcode 94h, address and mode on four lines, four dummy clocks, ids repeat
// [R5] security erase 44h, program 42h, read 48h take 24-bit address; read has dummy
// [R6] security address high byte 00h, middle 10h/20h/30h picks register, low is offset
// [R7] opcode 06h sets the write enable latch
// [R8] program, erase, security and non-volatile status writes need the latch set beforehand
// [R9] opcode 50h leaves the latch alone and arms the next status write as volatile
// [R10] opcode 04h clears the latch and cancels a volatile arm
// [R11] latch clears at power-up and when any write, program or erase cycle ends
// [R12] 05h reads status byte one, 35h byte two, MSB first on falling clock edges
// [R13] status reads always accepted, byte repeats until deselect for busy polling
// [R14] status write changes only bits 7..2 and writable bits 14..8
// [R15] lock bits never return to zero; volatile writes cannot clear sr_protect_1
// [R16] status write must end after exactly eight or sixteen data bits, else discarded
// [R17] eight-bit status write also clears complement protect and quad enable
// [R18] non-volatile status write runs a timed busy cycle, then clears the latch
// [R19] volatile status write updates bits right after deselect, busy stays low
// [R20] status bits reset to zero; non-volatile copy reloaded at power-on
// [R21] 03h takes 24-bit address, streams bytes MSB first with address increment
// [R22] 03h while busy is ignored completely
// [R23] write, program, erase must end on a byte boundary, reads may end anywhere
// [R24] while busy every instruction except status read is ignored
// [R25] all bytes move most significant bit first
// [R26] opcode from first eight rising clocks, decoder reset at every deselect
// ****************************************************************

module fsid_cmd #(
  parameter TW_CYCLES = `FSID_TW_CYCLES,
  parameter [7:0] MFR_ID = 8'hA5,   // arbitrary value
  parameter [7:0] DEV_ID = 8'h5A,   // arbitrary value
  parameter FIFO_DEPTH = 2,
  parameter FIFO_WIDTH = 8
) (
  input wire clk_i,                         // system clock, 50 MHz
  input wire rst_n_i,                       // synchronous reset, active low
  input wire cs_n_i,                        // chip select pin, active low
  input wire sclk_i,                        // serial clock pin
  input wire [3:0] io_i,                    // io pins in, io0 is serial_in
  output reg [3:0] io_o,                    // io pins out, io1 is serial out
  output reg [3:0] io_oe_o,                 // io pin drive enables
  output reg mem_req_valid_o,               // memory byte request valid
  input wire mem_req_ready_i,               // memory takes request
  output reg [23:0] mem_req_addr_o,         // request byte address
  output reg mem_req_sec_o,                 // request targets security area
  input wire mem_rsp_valid_i,               // memory byte returned
  input wire [FIFO_WIDTH-1:0] mem_rsp_data_i, // returned byte
  output reg mem_rsp_ready_o,               // buffer can take a byte
  output reg op_start_o,                    // program or erase cycle start pulse
  output reg [7:0] op_code_o,               // opcode of started cycle
  output reg [23:0] op_addr_o,              // address of started cycle
  input wire op_done_i,                     // program or erase cycle finished
  output reg wr_valid_o,                    // program data byte pulse
  output reg [7:0] wr_data_o,               // program data byte
  input wire [15:0] nv_load_i,              // stored non-volatile status
  output reg nv_store_o,                    // store non-volatile status pulse
  output reg [15:0] nv_data_o,              // status word to store
  output reg [15:0] status_o                // live status word
);

  localparam PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam [PW:0] DEPTH_C = FIFO_DEPTH[PW:0];

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg cs_s1_reg, cs_s2_reg, cs_s3_reg;
  reg ck_s1_reg, ck_s2_reg, ck_s3_reg;
  reg [3:0] io_s1_reg, io_s2_reg;

  // two flops per pin, third stage only for edge finding
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
      io_s1_reg <= 4'h0;
      io_s2_reg <= 4'h0;
    end else begin
      cs_s1_reg <= cs_n_i;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      ck_s1_reg <= sclk_i;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      io_s1_reg <= io_i;
      io_s2_reg <= io_s1_reg;
    end
  end

  wire sck_rise = ck_s2_reg & ~ck_s3_reg & ~cs_s2_reg;
  wire sck_fall = ~ck_s2_reg & ck_s3_reg & ~cs_s2_reg;
  wire frame_end = cs_s2_reg & ~cs_s3_reg;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // security window check, used for erase, program and read
  function sec_ok;
    input [23:0] a;
    begin
      sec_ok = (a[23:16] == `FSID_SEC_HI) && ((a[15:8] == `FSID_SEC_REG1) ||
               (a[15:8] == `FSID_SEC_REG2) || (a[15:8] == `FSID_SEC_REG3)); // [R6]
    end
  endfunction

  // first output clock of each read-type opcode
  function [6:0] data_start;
    input [7:0] op;
    begin
      case (op)
        `FSID_OP_RDSR1: data_start = `FSID_OPC_CLKS;       // [R12]
        `FSID_OP_RDSR2: data_start = `FSID_OPC_CLKS;       // [R12]
        `FSID_OP_READ: data_start = `FSID_ADDR_END;        // [R21]
        `FSID_OP_RPD_ID: data_start = `FSID_ADDR_END;      // [R1]
        `FSID_OP_MFID: data_start = `FSID_ADDR_END;        // [R2]
        `FSID_OP_MFID_DUAL: data_start = `FSID_DUAL_START; // [R3]
        `FSID_OP_MFID_QUAD: data_start = `FSID_QUAD_START; // [R4]
        `FSID_OP_SEC_READ: data_start = `FSID_SECRD_START; // [R5]
        default: data_start = `FSID_NO_DATA;
      endcase
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  reg [6:0] cnt_reg;
  reg [2:0] bmod_reg;
  reg [7:0] op_reg;
  reg [31:0] in_sr_reg;
  reg ign_reg;
  reg [23:0] addr_reg;
  reg rd_act_reg;
  reg [1:0] pos_reg;
  reg par_reg;
  reg [7:0] obuf_reg;
  reg [15:0] st_reg;
  reg wel_reg, arm_reg, nvw_busy_reg, op_busy_reg, init_reg;
  reg [31:0] tw_cnt_reg;
  reg flush_reg;
  reg [1:0] outst_reg;
  reg [FIFO_WIDTH-1:0] fifo_mem [0:FIFO_DEPTH-1];
  reg [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  reg [PW:0] fifo_cnt_reg;

  wire busy = nvw_busy_reg | op_busy_reg;
  wire [15:0] st_word = {st_reg[15:2], wel_reg, busy};
  wire opc_done = (cnt_reg >= `FSID_OPC_CLKS);
  wire [7:0] opc_next = {in_sr_reg[6:0], io_s2_reg[0]};
  wire [23:0] addr_next = {in_sr_reg[22:0], io_s2_reg[0]};
  wire is_rd = (op_reg == `FSID_OP_READ) || (op_reg == `FSID_OP_SEC_READ);
  wire out_on = opc_done && !ign_reg && (cnt_reg >= data_start(op_reg));

  // width of the serial lane for the current phase
  reg [2:0] lane_w;
  always @* begin
    lane_w = 3'd1;
    if (opc_done && op_reg == `FSID_OP_MFID_DUAL)
      lane_w = 3'd2; // [R3]
    if (opc_done && op_reg == `FSID_OP_MFID_QUAD)
      lane_w = 3'd4; // [R4]
  end
  wire [1:0] pos_last = (lane_w == 3'd4) ? 2'd1 : (lane_w == 3'd2) ? 2'd3 : 2'd3;
  wire [2:0] bit_last = (lane_w == 3'd1) ? 3'd7 : 3'd0;

  // ****************************************************************
  // buffer between memory answers and the serial shifter
  // ****************************************************************
  wire fifo_push = mem_rsp_valid_i & mem_rsp_ready_o & rd_act_reg & ~flush_reg;
  wire fifo_pop = sck_fall & out_on & is_rd & (pos_reg == 2'd0) & (bmod_reg == 3'd0) &
                  (fifo_cnt_reg != {(PW+1){1'b0}});
  wire [PW:0] fifo_cnt_next = frame_end ? {(PW+1){1'b0}} :
                              fifo_cnt_reg + {{PW{1'b0}}, fifo_push} - {{PW{1'b0}}, fifo_pop};
  wire req_fire = mem_req_valid_o & mem_req_ready_i;
  wire rsp_fire = mem_rsp_valid_i & mem_rsp_ready_o;
  wire [PW+1:0] inflight = {1'b0, fifo_cnt_reg} + {{PW{1'b0}}, outst_reg};
  wire can_issue = rd_act_reg & ~flush_reg & ~mem_req_valid_o & ~frame_end &
                   (inflight < {1'b0, DEPTH_C});

  // buffer storage and pointers; stale answers after deselect are dropped
  always @(posedge clk_i) begin
    if (fifo_push)
      fifo_mem[wr_ptr_reg] <= mem_rsp_data_i;
    if (!rst_n_i || frame_end) begin
      wr_ptr_reg <= {PW{1'b0}};
      rd_ptr_reg <= {PW{1'b0}};
    end else begin
      if (fifo_push)
        wr_ptr_reg <= (wr_ptr_reg == FIFO_DEPTH - 1) ? {PW{1'b0}} : wr_ptr_reg + 1'b1;
      if (fifo_pop)
        rd_ptr_reg <= (rd_ptr_reg == FIFO_DEPTH - 1) ? {PW{1'b0}} : rd_ptr_reg + 1'b1;
    end
  end

  // request side: credit limit keeps answers from ever overrunning the buffer
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      fifo_cnt_reg <= {(PW+1){1'b0}};
      mem_rsp_ready_o <= 1'b1;
      mem_req_valid_o <= 1'b0;
      mem_req_addr_o <= 24'h00_0000;
      mem_req_sec_o <= 1'b0;
      outst_reg <= 2'd0;
      flush_reg <= 1'b0;
    end else begin
      fifo_cnt_reg <= fifo_cnt_next;
      mem_rsp_ready_o <= (fifo_cnt_next < DEPTH_C);
      outst_reg <= outst_reg + {1'b0, req_fire} - {1'b0, rsp_fire};
      if (req_fire)
        mem_req_valid_o <= 1'b0;
      else if (can_issue)
        mem_req_valid_o <= 1'b1;
      if (req_fire)
        mem_req_addr_o <= mem_req_addr_o + 24'h00_0001; // [R21]
      else if (sck_rise && cnt_reg == `FSID_ADDR_END - 7'd1) begin
        mem_req_addr_o <= addr_next;
        mem_req_sec_o <= (op_reg == `FSID_OP_SEC_READ);
      end
      if (frame_end)
        flush_reg <= 1'b1;
      else if (outst_reg == 2'd0 && !mem_req_valid_o)
        flush_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // status write value
  // ****************************************************************
  reg [15:0] sw_new;
  reg [7:0] sw_b1;
  always @* begin
    sw_b1 = (cnt_reg == `FSID_WRSR_LONG) ? in_sr_reg[15:8] : in_sr_reg[7:0];
    sw_new[7:0] = (st_reg[7:0] & ~`FSID_SR1_WMASK) | (sw_b1 & `FSID_SR1_WMASK); // [R14]
    if (cnt_reg == `FSID_WRSR_LONG) begin
      sw_new[15:8] = (st_reg[15:8] & ~`FSID_SR2_WMASK) | (in_sr_reg[7:0] & `FSID_SR2_WMASK);
    end else begin
      sw_new[15:8] = st_reg[15:8];
      sw_new[`FSID_BIT_CMP] = 1'b0; // [R17]
      sw_new[`FSID_BIT_QE] = 1'b0;  // [R17]
    end
    sw_new[`FSID_LB_HI:`FSID_LB_LO] = sw_new[`FSID_LB_HI:`FSID_LB_LO] |
                                      st_reg[`FSID_LB_HI:`FSID_LB_LO]; // [R15]
    if (arm_reg)
      sw_new[`FSID_BIT_SR_PROTECT_1] = sw_new[`FSID_BIT_SR_PROTECT_1] | st_reg[`FSID_BIT_SR_PROTECT_1]; // [R15]
    sw_new[1:0] = 2'b00;
  end

  wire wrsr_len_ok = (cnt_reg == `FSID_WRSR_SHORT) || (cnt_reg == `FSID_WRSR_LONG); // [R16]
  wire byte_edge = (bmod_reg == 3'd0);                                                // [R23]
  wire sec_ok_now = sec_ok(addr_reg);

  // ****************************************************************
  // serial input side and frame decode
  // ****************************************************************
  // counters and opcode restart at every deselect
  always @(posedge clk_i) begin
    if (!rst_n_i || cs_s2_reg) begin
      cnt_reg <= 7'd0; // [R26]
      bmod_reg <= 3'd0;
      in_sr_reg <= 32'h0000_0000;
      op_reg <= 8'h00;
      ign_reg <= 1'b0;
      addr_reg <= 24'h00_0000;
      rd_act_reg <= 1'b0;
      wr_valid_o <= 1'b0;
    end else begin
      wr_valid_o <= 1'b0;
      if (sck_rise) begin
        if (lane_w == 3'd4)
          in_sr_reg <= {in_sr_reg[27:0], io_s2_reg}; // [R4]
        else if (lane_w == 3'd2)
          in_sr_reg <= {in_sr_reg[29:0], io_s2_reg[1:0]}; // [R3]
        else
          in_sr_reg <= {in_sr_reg[30:0], io_s2_reg[0]}; // [R25]
        if (cnt_reg != `FSID_NO_DATA)
          cnt_reg <= cnt_reg + 7'd1;
        bmod_reg <= bmod_reg + 3'd1;
        if (cnt_reg == `FSID_OPC_CLKS - 7'd1) begin
          op_reg <= opc_next; // [R26]
          ign_reg <= busy && (opc_next != `FSID_OP_RDSR1) &&
                     (opc_next != `FSID_OP_RDSR2); // [R13] [R22] [R24]
        end
        if (cnt_reg == `FSID_ADDR_END - 7'd1) begin
          addr_reg <= addr_next; // [R5] [R21]
          rd_act_reg <= !ign_reg && ((op_reg == `FSID_OP_READ) ||
                        (op_reg == `FSID_OP_SEC_READ && sec_ok(addr_next)));
        end
        // forward program data bytes as each completes
        if (!ign_reg && cnt_reg >= `FSID_ADDR_END && bmod_reg == 3'd7 &&
            ((op_reg == `FSID_OP_PP) || (op_reg == `FSID_OP_QPP) ||
             (op_reg == `FSID_OP_SEC_PROG))) begin
          wr_valid_o <= 1'b1; // [R5]
          wr_data_o <= {in_sr_reg[6:0], io_s2_reg[0]};
        end
      end
    end
  end

  // ****************************************************************
  // serial output side, driven on falling clock edges
  // ****************************************************************
  reg [7:0] next_byte;
  always @* begin
    case (op_reg)
      `FSID_OP_RDSR1: next_byte = st_word[7:0];   // [R12] [R13]
      `FSID_OP_RDSR2: next_byte = st_word[15:8];  // [R12]
      `FSID_OP_RPD_ID: next_byte = DEV_ID;        // [R1]
      `FSID_OP_READ, `FSID_OP_SEC_READ:
        next_byte = (fifo_cnt_reg != {(PW+1){1'b0}}) ? fifo_mem[rd_ptr_reg] : 8'h00;
      default: next_byte = par_reg ? DEV_ID : MFR_ID; // [R2] [R3] [R4]
    endcase
  end
  wire [7:0] sh_byte = (pos_reg == 2'd0 && (bmod_reg == 3'd0 || lane_w > 3'd1)) ?
                       next_byte : obuf_reg;

  // one byte loads per byte time, then shifts out msb first
  always @(posedge clk_i) begin
    if (!rst_n_i || cs_s2_reg) begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
      pos_reg <= 2'd0;
      par_reg <= 1'b0;
      obuf_reg <= 8'h00;
    end else if (sck_fall && out_on) begin
      if (lane_w == 3'd4) begin
        io_o <= sh_byte[7:4];
        io_oe_o <= 4'hF;
        obuf_reg <= {sh_byte[3:0], 4'h0};
      end else if (lane_w == 3'd2) begin
        io_o <= {2'b00, sh_byte[7:6]};
        io_oe_o <= 4'h3;
        obuf_reg <= {sh_byte[5:0], 2'b00};
      end else begin
        io_o <= {2'b00, sh_byte[7], 1'b0}; // [R25]
        io_oe_o <= 4'h2;
        obuf_reg <= {sh_byte[6:0], 1'b0};
      end
      // single lane counts bits in bmod; wide lanes count clocks in pos
      if (lane_w == 3'd1) begin
        if (bmod_reg == bit_last)
          par_reg <= ~par_reg;
      end else begin
        pos_reg <= (pos_reg == pos_last) ? 2'd0 : pos_reg + 2'd1;
        if (pos_reg == pos_last)
          par_reg <= ~par_reg;
      end
    end
  end

  // ****************************************************************
  // latch, status and busy control at frame end
  // ****************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      init_reg <= 1'b1;
      st_reg <= `FSID_SR_RESET; // [R20]
      wel_reg <= 1'b0;          // [R11]
      arm_reg <= 1'b0;
      nvw_busy_reg <= 1'b0;
      op_busy_reg <= 1'b0;
      tw_cnt_reg <= 32'h0000_0000;
      nv_store_o <= 1'b0;
      nv_data_o <= 16'h0000;
      op_start_o <= 1'b0;
      op_code_o <= 8'h00;
      op_addr_o <= 24'h00_0000;
      status_o <= 16'h0000;
    end else begin
      nv_store_o <= 1'b0;
      op_start_o <= 1'b0;
      status_o <= st_word;
      init_reg <= 1'b0;
      if (init_reg)
        st_reg <= nv_load_i & {`FSID_SR2_WMASK, `FSID_SR1_WMASK}; // [R20]
      // timed non-volatile status cycle
      if (nvw_busy_reg) begin
        if (tw_cnt_reg == 32'h0000_0001) begin
          nvw_busy_reg <= 1'b0; // [R18]
          wel_reg <= 1'b0;      // [R11] [R18]
        end
        tw_cnt_reg <= tw_cnt_reg - 32'h0000_0001;
      end
      if (op_busy_reg && op_done_i) begin
        op_busy_reg <= 1'b0;
        wel_reg <= 1'b0; // [R11]
      end
      if (frame_end && !ign_reg && opc_done) begin
        if (op_reg != `FSID_OP_VWREN)
          arm_reg <= 1'b0; // [R9]
        case (op_reg)
          `FSID_OP_WREN: if (cnt_reg == `FSID_OPC_CLKS)
            wel_reg <= 1'b1; // [R7]
          `FSID_OP_VWREN: if (cnt_reg == `FSID_OPC_CLKS)
            arm_reg <= 1'b1; // [R9]
          `FSID_OP_WRDI: if (cnt_reg == `FSID_OPC_CLKS) begin
            wel_reg <= 1'b0; // [R10]
            arm_reg <= 1'b0; // [R10]
          end
          `FSID_OP_WRSR: if (wrsr_len_ok) begin // [R16]
            if (arm_reg) begin
              st_reg <= sw_new; // [R19]
            end else if (wel_reg) begin // [R8]
              st_reg <= sw_new;
              nv_store_o <= 1'b1;
              nv_data_o <= sw_new;
              nvw_busy_reg <= 1'b1; // [R18]
              tw_cnt_reg <= TW_CYCLES;
            end
          end
          `FSID_OP_PP, `FSID_OP_QPP, `FSID_OP_SEC_PROG:
            if (wel_reg && byte_edge && cnt_reg > `FSID_ADDR_END &&
                (op_reg != `FSID_OP_SEC_PROG || sec_ok_now)) begin // [R8] [R23]
              op_start_o <= 1'b1;
              op_busy_reg <= 1'b1;
              op_code_o <= op_reg;
              op_addr_o <= addr_reg;
            end
          `FSID_OP_SE, `FSID_OP_BE32, `FSID_OP_BE64, `FSID_OP_SEC_ERASE:
            if (wel_reg && cnt_reg == `FSID_ADDR_END &&
                (op_reg != `FSID_OP_SEC_ERASE || sec_ok_now)) begin // [R8] [R23]
              op_start_o <= 1'b1;
              op_busy_reg <= 1'b1;
              op_code_o <= op_reg;
              op_addr_o <= addr_reg;
            end
          `FSID_OP_CE1, `FSID_OP_CE2:
            if (wel_reg && cnt_reg == `FSID_OPC_CLKS) begin // [R8] [R23]
              op_start_o <= 1'b1;
              op_busy_reg <= 1'b1;
              op_code_o <= op_reg;
              op_addr_o <= 24'h00_0000;
            end
          default: ;
        endcase
      end
    end
  end

endmodule

// file: fsid_cmd_checker.sv
// fsid_cmd_checker.sv: port assertions for the command decoder
`timescale 1ns/100ps
module fsid_cmd_checker #(parameter TW_CYCLES = 20) (
  input wire clk_i, // clock
  input wire rst_n_i, // reset
  input wire cs_n_i, // select
  input wire [3:0] io_oe_o, // pin enables
  input wire mem_req_valid_o, // request
  input wire mem_req_ready_i, // taken
  input wire [23:0] mem_req_addr_o, // address
  input wire op_start_o, // cycle start
  input wire op_done_i, // cycle end
  input wire [15:0] status_o // status
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reg [31:0] busy_cnt_reg;
  // busy length, so a cut short status write cycle is seen
  always @(posedge clk_i) begin
    busy_cnt_reg <= status_o[0] ? busy_cnt_reg + 32'd1 : 32'd0;
  end
  sequence s_stall; mem_req_valid_o && !mem_req_ready_i; endsequence
  sequence s_quiet; cs_n_i [*6]; endsequence
  hold_req_a: assert property (s_stall |=> mem_req_valid_o && $stable(mem_req_addr_o))
    else $error("request moved while stalled");
  idle_req_a: assert property ($rose(mem_req_valid_o) |-> !status_o[0])
    else $error("read request while busy");
  start_wel_a: assert property (op_start_o |-> status_o[1])
    else $error("start without latch");
  start_busy_a: assert property (op_start_o |-> ##[0:3] status_o[0])
    else $error("start without busy");
  busy_hold_a: assert property (status_o[0] && $past(status_o[0]) |-> !op_start_o)
    else $error("start while busy");
  end_wel_a: assert property ($fell(status_o[0]) |-> ##[0:2] !status_o[1])
    else $error("latch kept after cycle");
  busy_len_a: assert property ($fell(status_o[0]) |->
    $past(op_done_i) || busy_cnt_reg >= TW_CYCLES - 2) else $error("cycle too short");
  quiet_a: assert property (s_quiet |-> io_oe_o == 4'h0)
    else $error("pins driven when deselected");
  lanes_a: assert property (io_oe_o != 4'h0 |-> io_oe_o inside {4'h2, 4'h3, 4'hf})
    else $error("odd lane enable");
endmodule

// file: fsid_host.sv
// fsid_host.sv: host end of the serial link, one frame per call
`timescale 1ns/100ps
module fsid_host (
  input wire clk_i, // clock
  input wire miso_i, // serial out
  output reg cs_n_o, // select, active low
  output reg sclk_o, // serial clock
  output reg mosi_o // serial_in
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // eight clocks a bit; reply taken late in the high phase, long after it settles
  task xfer(input [63:0] tx, input integer n, output [63:0] rx);
    integer i;
    begin
      rx = 64'h0;
      @(posedge clk_i) cs_n_o <= 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        mosi_o <= tx[i];
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 rx = {rx[62:0], miso_i};
        @(posedge clk_i) sclk_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule

// file: fsid_cmd_tb.sv
// fsid_cmd_tb.sv: bench with host, memory stub and status model
`timescale 1ns/100ps
module fsid_cmd_tb;
  localparam TW = 2000;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg mem_req_ready_i = 1'b1;
  reg mem_rsp_valid_i = 1'b0;
  reg [7:0] mem_rsp_data_i = 8'h00;
  reg op_done_i = 1'b0;
  reg op_pend = 1'b0;
  reg [15:0] nv_load_i = 16'h0000;
  wire cs_n, sclk, mosi, mem_req_valid_o, op_start_o;
  wire [3:0] io_o, io_oe_o;
  wire [23:0] mem_req_addr_o;
  wire [15:0] status_o;
  // io1 is pulled up when the device leaves it
  wire io1 = io_oe_o[1] ? io_o[1] : 1'b1;
  integer seed = 32'hde74;
  integer fail_count = 0;
  integer checks = 0;
  integer sr, starts = 0, reqs = 0;
  reg [63:0] rx;
  reg [23:0] a;
  reg [15:0] v;
  initial forever #10 clk_i = ~clk_i;
  fsid_host host (.clk_i(clk_i), .miso_i(io1), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));
  // ids are arbitrary
  fsid_cmd #(.TW_CYCLES(TW), .MFR_ID(8'hc3), .DEV_ID(8'h3c)) dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i({2'b11, io1, mosi}), .io_o(io_o),
    .io_oe_o(io_oe_o), .mem_req_valid_o(mem_req_valid_o), .mem_req_ready_i(mem_req_ready_i),
    .mem_req_addr_o(mem_req_addr_o), .mem_req_sec_o(), .mem_rsp_valid_i(mem_rsp_valid_i),
    .mem_rsp_data_i(mem_rsp_data_i), .mem_rsp_ready_o(), .op_start_o(op_start_o),
    .op_code_o(), .op_addr_o(), .op_done_i(op_done_i), .wr_valid_o(), .wr_data_o(),
    .nv_load_i(nv_load_i), .nv_store_o(), .nv_data_o(), .status_o(status_o));
  // memory stub: odd requests stall a clock; cycle end held until busy drops
  always @(posedge clk_i) begin
    mem_req_ready_i <= ~reqs[0] | (mem_req_valid_o & ~mem_req_ready_i);
    mem_rsp_valid_i <= mem_req_valid_o & mem_req_ready_i;
    mem_rsp_data_i <= mem_req_addr_o[7:0] ^ 8'h5c;
    op_pend <= op_start_o | (op_pend & ~op_done_i);
    op_done_i <= status_o[0] & (op_done_i | op_pend);
    if (op_start_o) starts <= starts + 1;
    if (mem_req_valid_o & mem_req_ready_i) reqs <= reqs + 1;
  end
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task cmd(input [7:0] op);
    host.xfer(op, 8, rx);
  endtask
  // both status bytes, each twice
  task st;
    begin
      host.xfer({8'h05, 16'h0}, 24, rx);
      chk(rx[15:0], {2{sr[7:0]}});
      host.xfer({8'h35, 16'h0}, 24, rx);
      chk(rx[15:0], {2{sr[15:8]}});
    end
  endtask
  task idle;
    integer k;
    begin
      k = 0;
      while (status_o[0] !== 1'b0 && k < 3000) begin
        @(posedge clk_i);
        k = k + 1;
      end
    end
  endtask
  task print_verdict;
    begin
      if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #1_000_000;
    fail_count = fail_count + 1;
    print_verdict;
  end
  initial begin
    nv_load_i = $random(seed);
    v = $random(seed);
    a = $random(seed);
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    sr = nv_load_i & 16'h7bfc;
    chk(status_o, sr);
    cmd(8'h06);
    sr = sr | 2;
    st;
    cmd(8'h50);
    st;
    cmd(8'h04);
    host.xfer({8'h01, v}, 24, rx);
    sr = sr & ~2;
    st;
    cmd(8'h50);
    host.xfer({8'h01, v[7:0], v[15:8]}, 24, rx);
    sr = (v & 16'h7bfc) | (sr & 16'h3903);
    st;
    cmd(8'h50);
    host.xfer({8'h01, v[15:8]}, 16, rx);
    sr = (sr & 16'hbd03) | (v[15:8] & 8'hfc);
    st;
    cmd(8'h50);
    host.xfer({8'h01, v[11:0]}, 20, rx);
    st;
    cmd(8'h04);
    cmd(8'h06);
    host.xfer({8'h01, a[7:0], a[15:8]}, 24, rx);
    sr = (a[15:0] & 16'h7bfc) | (sr & 16'h3800) | 3;
    st;
    host.xfer({8'h03, a, 24'h0}, 56, rx);
    chk(reqs, 0);
    idle;
    sr = sr & ~3;
    st;
    host.xfer({8'h03, a, 24'h0}, 56, rx);
    chk(rx[23:0], {a[7:0] ^ 8'h5c, a[7:0] + 8'd1 ^ 8'h5c, a[7:0] + 8'd2 ^ 8'h5c});
    host.xfer({8'h90, 40'h0}, 48, rx);
    chk(rx[15:0], 16'hc33c);
    host.xfer({8'hab, 40'h0}, 48, rx);
    chk(rx[15:0], 16'h3c3c);
    host.xfer({8'h20, a}, 32, rx);
    chk(starts, 0);
    cmd(8'h06);
    host.xfer({8'h20, a}, 32, rx);
    idle;
    chk(starts, 1);
    st;
    print_verdict;
  end
endmodule
bind fsid_cmd fsid_cmd_checker #(.TW_CYCLES(TW_CYCLES)) chk_u (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o), .mem_req_valid_o(mem_req_valid_o),
  .mem_req_ready_i(mem_req_ready_i), .mem_req_addr_o(mem_req_addr_o),
  .op_start_o(op_start_o), .op_done_i(op_done_i), .status_o(status_o));
